// File: core/xem_access.sv
// Purpose: effective address, on-chip ram and off-chip pin sequencing for external moves
// Assumes: core requests are on pclk; pin inputs come from outside and are synchronised
// Notes:   apb slave answers with pready one cycle after setup, never stretched
// Function
// - 256 bytes of on-chip ram live in the external data space only.
// - pointer form uses the full 16-bit data pointer as address.
// - data pointer reads and writes as separate high and low bytes.
// - index form takes the high address byte from page select.
// - index form takes the low byte from the named index register.
// - writes target data ram unless flash writing is enabled; reads always do.
// - interface owns its pins only during an off-chip move.
// - after an off-chip move every pin returns to its port latch.
// - pins acting as inputs, like data during reads, are not driven.
// - push-pull or open-drain mode comes only from the mode register.
// - page select is 8-bit rw at index 0xaa, resets to zero.
// - mux select bit clear shares address and data pins, set separates them.
// - mode 00 keeps all on-chip, mode 11 sends all off-chip.
// - mode 01 splits at 256; off-chip index form uses high latch.
// - mode 10 splits at 256; off-chip index form uses page select.
//
// Added by the designer: the APB slave port.
module xem_access (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic [11:0]           paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // external-move requests from the core
  input  wire logic                  mv_valid,
  input  wire xem_pkg::xem_req_s     mv_req,
  output logic                       mv_ready,
  output logic                       mv_done,
  output logic      [7:0]            mv_rdata,
  // flash write hand-off
  output logic                       fl_wr,
  output logic      [15:0]           fl_addr,
  output logic      [7:0]            fl_data,
  // memory-interface pins
  input  wire xem_pkg::xem_pins_s    pin_in,
  output xem_pkg::xem_pins_s         pin_out,
  output xem_pkg::xem_pins_s         pin_oe
);

  // register file
  logic [7:0]  page_r, page_nxt;
  logic [7:0]  ptr_lo_r, ptr_lo_nxt;
  logic [7:0]  ptr_hi_r, ptr_hi_nxt;
  logic [7:0]  idx_a_r, idx_a_nxt;
  logic [7:0]  idx_b_r, idx_b_nxt;
  logic [4:0]  cfg_r, cfg_nxt;
  logic        flash_en_r, flash_en_nxt;
  logic [26:0] latch_r, latch_nxt;
  logic [26:0] pmode_r, pmode_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt;
  logic        pslverr_r, pslverr_nxt;

  // sequencer
  xem_pkg::xem_state_e state_r, state_nxt;
  logic [15:0] ea_r, ea_nxt;
  logic        wr_r, wr_nxt;
  logic [7:0]  wd_r, wd_nxt;
  logic [2:0]  cnt_r, cnt_nxt;
  logic        ready_r, ready_nxt;
  logic        done_r, done_nxt;
  logic [7:0]  rdata_r, rdata_nxt;
  logic        fl_wr_r, fl_wr_nxt;
  logic        last_off_r, last_off_nxt;

  logic [7:0]  ram [xem_pkg::XEM_RAM_BYTES];
  logic [7:0]  ad_meta_r;
  logic [7:0]  ad_sync_r;

  logic        setup;
  logic        wr_done;
  logic        accept;
  logic        ram_we;
  logic        mux_sep;
  logic [1:0]  mode;
  logic [15:0] ea_req;
  logic        off_req;
  xem_pkg::xem_pins_s own_v, val_v, drv_v;

  assign setup   = psel && !penable;
  assign wr_done = psel && penable && pready_r && pwrite;
  assign accept  = mv_valid && ready_r;
  assign mux_sep = cfg_r[xem_pkg::XEM_CFG_MUX_BIT];
  assign mode    = cfg_r[xem_pkg::XEM_CFG_MODE_LSB +: 2];

  // apb register group
  always_comb
  begin
    page_nxt     = page_r;
    ptr_lo_nxt   = ptr_lo_r;
    ptr_hi_nxt   = ptr_hi_r;
    idx_a_nxt    = idx_a_r;
    idx_b_nxt    = idx_b_r;
    cfg_nxt      = cfg_r;
    flash_en_nxt = flash_en_r;
    latch_nxt    = latch_r;
    pmode_nxt    = pmode_r;
    prdata_nxt   = prdata_r;
    pslverr_nxt  = pslverr_r;
    pready_nxt   = setup;
    if (setup)
    begin
      pslverr_nxt = 1'b0;
      unique case (paddr)
        xem_pkg::XEM_A_PAGE:   prdata_nxt = {24'h000000, page_r};
        xem_pkg::XEM_A_PTR_LO: prdata_nxt = {24'h000000, ptr_lo_r};
        xem_pkg::XEM_A_PTR_HI: prdata_nxt = {24'h000000, ptr_hi_r};
        xem_pkg::XEM_A_IDX_A:  prdata_nxt = {24'h000000, idx_a_r};
        xem_pkg::XEM_A_IDX_B:  prdata_nxt = {24'h000000, idx_b_r};
        xem_pkg::XEM_A_CFG:    prdata_nxt = {27'h0000000, cfg_r};
        xem_pkg::XEM_A_CTL:    prdata_nxt = {31'h00000000, flash_en_r};
        xem_pkg::XEM_A_LATCH:  prdata_nxt = {5'h00, latch_r};
        xem_pkg::XEM_A_PMODE:  prdata_nxt = {5'h00, pmode_r};
        xem_pkg::XEM_A_STATUS: prdata_nxt = {26'h0000000, last_off_r, !ready_r, state_r};
        default:
        begin
          prdata_nxt  = 32'h00000000;
          pslverr_nxt = 1'b1;
        end
      endcase
    end
    // writes land only at the completing edge, so a move taken there sees the old page
    if (wr_done)
    begin
      unique case (paddr)
        xem_pkg::XEM_A_PAGE:   page_nxt     = pwdata[7:0];
        xem_pkg::XEM_A_PTR_LO: ptr_lo_nxt   = pwdata[7:0];
        xem_pkg::XEM_A_PTR_HI: ptr_hi_nxt   = pwdata[7:0];
        xem_pkg::XEM_A_IDX_A:  idx_a_nxt    = pwdata[7:0];
        xem_pkg::XEM_A_IDX_B:  idx_b_nxt    = pwdata[7:0];
        xem_pkg::XEM_A_CFG:    cfg_nxt      = pwdata[4:0];
        xem_pkg::XEM_A_CTL:    flash_en_nxt = pwdata[xem_pkg::XEM_CTL_FLASH];
        xem_pkg::XEM_A_LATCH:  latch_nxt    = pwdata[26:0];
        xem_pkg::XEM_A_PMODE:  pmode_nxt    = pwdata[26:0];
        default:               page_nxt     = page_r;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      page_r     <= xem_pkg::XEM_PAGE_RST;
      ptr_lo_r   <= 8'h00;
      ptr_hi_r   <= 8'h00;
      idx_a_r    <= 8'h00;
      idx_b_r    <= 8'h00;
      cfg_r      <= xem_pkg::XEM_CFG_RST;
      flash_en_r <= 1'b0;
      latch_r    <= xem_pkg::XEM_LATCH_RST;
      pmode_r    <= xem_pkg::XEM_PMODE_RST;
      prdata_r   <= 32'h00000000;
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
    end
    else
    begin
      page_r     <= page_nxt;
      ptr_lo_r   <= ptr_lo_nxt;
      ptr_hi_r   <= ptr_hi_nxt;
      idx_a_r    <= idx_a_nxt;
      idx_b_r    <= idx_b_nxt;
      cfg_r      <= cfg_nxt;
      flash_en_r <= flash_en_nxt;
      latch_r    <= latch_nxt;
      pmode_r    <= pmode_nxt;
      prdata_r   <= prdata_nxt;
      pready_r   <= pready_nxt;
      pslverr_r  <= pslverr_nxt;
    end
  end

  // effective address and target of the offered move
  always_comb
  begin
    if (mv_req.ptr_form)
    begin
      ea_req = {ptr_hi_r, ptr_lo_r};
    end
    else
    begin
      ea_req = {page_r, mv_req.sel_b ? idx_b_r : idx_a_r};
    end
    unique case (mode)
      xem_pkg::XEM_MODE_ON_ONLY:  off_req = 1'b0;
      xem_pkg::XEM_MODE_OFF_ONLY: off_req = 1'b1;
      default:                    off_req = ea_req[15:8] != 8'h00;
    endcase
    // split mode without bank select drives the high byte from its port latch
    if (off_req && !mv_req.ptr_form && mode == xem_pkg::XEM_MODE_SPLIT_NB)
    begin
      ea_req = {latch_r[23:16], ea_req[7:0]};
    end
  end

  assign ram_we = accept && mv_req.write && !off_req && !flash_en_r;

  // sequencer group
  always_comb
  begin
    state_nxt    = state_r;
    ea_nxt       = ea_r;
    wr_nxt       = wr_r;
    wd_nxt       = wd_r;
    cnt_nxt      = cnt_r;
    ready_nxt    = ready_r;
    done_nxt     = 1'b0;
    rdata_nxt    = rdata_r;
    fl_wr_nxt    = 1'b0;
    last_off_nxt = last_off_r;
    unique case (state_r)
      xem_pkg::XEM_ST_IDLE:
      begin
        ready_nxt = 1'b1;
        if (accept)
        begin
          ready_nxt    = 1'b0;
          ea_nxt       = ea_req;
          wr_nxt       = mv_req.write;
          wd_nxt       = mv_req.wdata;
          last_off_nxt = off_req;
          if (mv_req.write && flash_en_r)
          begin
            fl_wr_nxt = 1'b1;
            done_nxt  = 1'b1;
          end
          else if (!off_req)
          begin
            rdata_nxt = mv_req.write ? rdata_r : ram[ea_req[7:0]];
            done_nxt  = 1'b1;
          end
          else
          begin
            state_nxt = xem_pkg::XEM_ST_ADDR;
          end
        end
      end
      xem_pkg::XEM_ST_ADDR:
      begin
        state_nxt = xem_pkg::XEM_ST_STRB;
        cnt_nxt   = xem_pkg::XEM_STRB_CYC;
      end
      xem_pkg::XEM_ST_STRB:
      begin
        cnt_nxt = cnt_r - 3'h1;
        if (cnt_r == 3'h1)
        begin
          // the strobe outlasts pin register plus synchroniser delay
          rdata_nxt = wr_r ? rdata_r : ad_sync_r;
          state_nxt = xem_pkg::XEM_ST_HOLD;
        end
      end
      xem_pkg::XEM_ST_HOLD:
      begin
        state_nxt = xem_pkg::XEM_ST_IDLE;
        done_nxt  = 1'b1;
        ready_nxt = 1'b1;
      end
      default:
      begin
        state_nxt = xem_pkg::XEM_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r    <= xem_pkg::XEM_ST_IDLE;
      ea_r       <= 16'h0000;
      wr_r       <= 1'b0;
      wd_r       <= 8'h00;
      cnt_r      <= 3'h0;
      ready_r    <= 1'b0;
      done_r     <= 1'b0;
      rdata_r    <= 8'h00;
      fl_wr_r    <= 1'b0;
      last_off_r <= 1'b0;
      ad_meta_r  <= 8'h00;
      ad_sync_r  <= 8'h00;
    end
    else
    begin
      state_r    <= state_nxt;
      ea_r       <= ea_nxt;
      wr_r       <= wr_nxt;
      wd_r       <= wd_nxt;
      cnt_r      <= cnt_nxt;
      ready_r    <= ready_nxt;
      done_r     <= done_nxt;
      rdata_r    <= rdata_nxt;
      fl_wr_r    <= fl_wr_nxt;
      last_off_r <= last_off_nxt;
      ad_meta_r  <= pin_in.ad;
      ad_sync_r  <= ad_meta_r;
    end
  end

  // ram contents carry no reset, like any sram
  always_ff @(posedge pclk)
  begin
    if (ram_we)
    begin
      ram[ea_req[7:0]] <= mv_req.wdata;
    end
  end

  // what the interface wants on its pins while it owns them
  always_comb
  begin
    own_v = '0;
    val_v = '1;
    drv_v = '0;
    if (state_r != xem_pkg::XEM_ST_IDLE)
    begin
      own_v.ctl = 3'h7;
      own_v.ahi = 8'hff;
      own_v.ad  = 8'hff;
      own_v.alo = mux_sep ? 8'hff : 8'h00;
      drv_v.ctl = 3'h7;
      drv_v.ahi = 8'hff;
      drv_v.alo = 8'hff;
      val_v.ahi = ea_r[15:8];
      val_v.alo = ea_r[7:0];
      val_v.ad  = wd_r;
      drv_v.ad  = wr_r ? 8'hff : 8'h00;
      if (state_r == xem_pkg::XEM_ST_ADDR)
      begin
        val_v.ctl[xem_pkg::XEM_PIN_ALE] = 1'b1;
        if (!mux_sep)
        begin
          val_v.ad = ea_r[7:0];
          drv_v.ad = 8'hff;
        end
      end
      else
      begin
        val_v.ctl[xem_pkg::XEM_PIN_ALE] = 1'b0;
      end
      if (state_r == xem_pkg::XEM_ST_STRB)
      begin
        val_v.ctl[xem_pkg::XEM_PIN_RDN] = wr_r;
        val_v.ctl[xem_pkg::XEM_PIN_WRN] = !wr_r;
      end
    end
  end

  xem_pin_drive #(
    .W (xem_pkg::XEM_PIN_W)
  ) u_pins (
    .pclk      (pclk),
    .presetn   (presetn),
    .latch     (latch_r),
    .push_pull (pmode_r),
    .own       (own_v),
    .val       (val_v),
    .drv       (drv_v),
    .pin_out   (pin_out),
    .pin_oe    (pin_oe)
  );

  assign prdata   = prdata_r;
  assign pready   = pready_r;
  assign pslverr  = pslverr_r;
  assign mv_ready = ready_r;
  assign mv_done  = done_r;
  assign mv_rdata = rdata_r;
  assign fl_wr    = fl_wr_r;
  assign fl_addr  = ea_r;
  assign fl_data  = wd_r;

endmodule

// File: include/xem_pkg.sv
// Purpose: shared constants and types of the external data memory access block
// Assumes: apb byte addresses are 12 bits; each register is one aligned word
// Notes:   page select index is 0xaa, and every register sits at four times its index
package xem_pkg;

  // register indices and byte addresses
  localparam logic [11:0] XEM_IDX_PAGE   = 12'h0aa;
  localparam logic [11:0] XEM_A_PAGE     = {XEM_IDX_PAGE[9:0], 2'b00};
  localparam logic [11:0] XEM_A_PTR_LO   = 12'h000;
  localparam logic [11:0] XEM_A_PTR_HI   = 12'h004;
  localparam logic [11:0] XEM_A_IDX_A    = 12'h008;
  localparam logic [11:0] XEM_A_IDX_B    = 12'h00c;
  localparam logic [11:0] XEM_A_CFG      = 12'h010;
  localparam logic [11:0] XEM_A_CTL      = 12'h014;
  localparam logic [11:0] XEM_A_LATCH    = 12'h018;
  localparam logic [11:0] XEM_A_PMODE    = 12'h01c;
  localparam logic [11:0] XEM_A_STATUS   = 12'h020;

  // field positions
  localparam int unsigned XEM_CFG_MUX_BIT  = 4;
  localparam int unsigned XEM_CFG_MODE_LSB = 2;
  localparam int unsigned XEM_CTL_FLASH    = 0;
  localparam int unsigned XEM_PIN_ALE      = 0;
  localparam int unsigned XEM_PIN_RDN      = 1;
  localparam int unsigned XEM_PIN_WRN      = 2;

  // values after reset
  localparam logic [7:0]  XEM_PAGE_RST  = 8'h00;
  localparam logic [4:0]  XEM_CFG_RST   = 5'h03;
  localparam logic [26:0] XEM_LATCH_RST = 27'h7ffffff;
  localparam logic [26:0] XEM_PMODE_RST = 27'h0000000;

  // sizes and cycle counts
  localparam int unsigned XEM_RAM_BYTES = 256;
  localparam logic [2:0]  XEM_STRB_CYC  = 3'h5;
  localparam int unsigned XEM_PIN_W     = 27;

  typedef enum logic [1:0] {
    XEM_MODE_ON_ONLY  = 2'h0,
    XEM_MODE_SPLIT_NB = 2'h1,
    XEM_MODE_SPLIT_B  = 2'h2,
    XEM_MODE_OFF_ONLY = 2'h3
  } xem_mode_e;

  typedef enum logic [3:0] {
    XEM_ST_IDLE = 4'h1,
    XEM_ST_ADDR = 4'h2,
    XEM_ST_STRB = 4'h4,
    XEM_ST_HOLD = 4'h8
  } xem_state_e;

  // one external-move instruction from the core
  typedef struct packed {
    logic       ptr_form;
    logic       sel_b;
    logic       write;
    logic [7:0] wdata;
  } xem_req_s;

  // memory-interface pin group, 27 bits
  typedef struct packed {
    logic [2:0] ctl;
    logic [7:0] ahi;
    logic [7:0] alo;
    logic [7:0] ad;
  } xem_pins_s;

endpackage

// File: core/xem_pin_drive.sv
// Purpose: per-pin ownership between the port latch and the memory interface
// Assumes: mode bit high means push-pull, low means open-drain
// Notes:   outputs are registered, one cycle behind the owner's request
module xem_pin_drive #(
  parameter int unsigned W = 27
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // port side
  input  wire logic [W-1:0] latch,
  input  wire logic [W-1:0] push_pull,
  // interface side
  input  wire logic [W-1:0] own,
  input  wire logic [W-1:0] val,
  input  wire logic [W-1:0] drv,
  // pins
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_oe
);

  logic [W-1:0] out_nxt;
  logic [W-1:0] oe_nxt;

  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      out_nxt[i] = own[i] ? val[i] : latch[i];
      // open-drain only ever pulls low; the mode is never touched here
      oe_nxt[i]  = (push_pull[i] || !out_nxt[i]) && !(own[i] && !drv[i]);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_out <= '1;
      pin_oe  <= '0;
    end
    else
    begin
      pin_out <= out_nxt;
      pin_oe  <= oe_nxt;
    end
  end

endmodule

// File: dv/xem_checker.sv
// Purpose: port-level checks of the external move block
// Assumes: bench keeps the strobe latches parked at one
// Notes:   strobe figures follow the five-cycle strobe setting
module xem_checker (
  // clock and reset
  input wire logic               pclk,
  input wire logic               presetn,
  // apb
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pready,
  input wire logic               pslverr,
  // moves
  input wire logic               mv_valid,
  input wire logic               mv_ready,
  input wire logic               mv_done,
  // pins
  input wire xem_pkg::xem_pins_s pin_out,
  input wire xem_pkg::xem_pins_s pin_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic take;
  logic rdn;
  logic wrn;
  assign take = mv_valid && mv_ready;
  assign rdn  = pin_out.ctl[xem_pkg::XEM_PIN_RDN];
  assign wrn  = pin_out.ctl[xem_pkg::XEM_PIN_WRN];
  sequence s_rd_low;
    !rdn [*5];
  endsequence
  sequence s_rd_end;
    s_rd_low ##1 rdn;
  endsequence
  a_apb_one_wait: assert property (psel && !penable |=> pready)
    else $error("pready late");
  a_slverr_with_ready: assert property ($rose(pslverr) |-> pready)
    else $error("pslverr without pready");
  a_take_drops_ready: assert property (take |=> !mv_ready)
    else $error("ready kept after take");
  a_done_in_time: assert property (take |-> ##[1:8] mv_done)
    else $error("move not done in time");
  a_rd_strobe_len: assert property ($fell(rdn) |-> s_rd_end)
    else $error("read strobe length");
  a_wr_strobe_len: assert property ($fell(wrn) |-> !wrn [*4] ##[1:2] wrn)
    else $error("write strobe length");
  a_pins_owned_busy: assert property ($fell(rdn) || $fell(wrn) |-> $past(!mv_ready) && $past(!mv_ready, 2))
    else $error("strobe outside a move");
  a_release_after_done: assert property ($rose(rdn) |-> mv_done)
    else $error("pins not returned with done");
  a_read_undriven: assert property (!rdn |-> pin_oe.ad == 8'h00)
    else $error("data driven during read");
endmodule

bind xem_access xem_checker u_chk (
  .pclk, .presetn, .psel, .penable, .pready, .pslverr,
  .mv_valid, .mv_ready, .mv_done, .pin_out, .pin_oe
);

// File: dv/xem_ext_mem.sv
// Purpose: off-chip byte memory behind the interface pins
// Assumes: address taken while ale is high and no strobe is low
// Notes:   released data lines toggle so a stale value never looks valid
module xem_ext_mem (
  // clock
  input  wire logic               pclk,
  // setup from the bench
  input  wire logic               shared,
  input  wire logic               slow,
  // pins
  input  wire xem_pkg::xem_pins_s pin_out,
  input  wire xem_pkg::xem_pins_s pin_oe,
  output xem_pkg::xem_pins_s      pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  mem [logic [15:0]];
  logic [15:0] addr = 16'h0000;
  logic [7:0]  last = 8'h00;
  logic [7:0]  drv;
  logic        rd_q = 1'b0;
  logic        rd;
  logic        wr;
  assign rd = !pin_out.ctl[xem_pkg::XEM_PIN_RDN];
  assign wr = !pin_out.ctl[xem_pkg::XEM_PIN_WRN];
  always @(posedge pclk)
  begin
    rd_q <= rd;
    last <= drv;
    if (pin_out.ctl[xem_pkg::XEM_PIN_ALE] && !rd && !wr)
      addr <= {pin_out.ahi, shared ? pin_out.ad : pin_out.alo};
    if (wr)
      mem[addr] = pin_out.ad;
  end
  // slow answers one cycle into the strobe
  always @*
  begin
    drv = ~last;
    if (rd && (rd_q || !slow) && mem.exists(addr))
      drv = mem[addr];
    pin_in    = pin_out;
    pin_in.ad = (pin_oe.ad & pin_out.ad) | (~pin_oe.ad & drv);
  end
endmodule

// File: dv/tb_external_data_ram_external_memory_access.sv
// Purpose: self-checking bench of the external move block
// Assumes: apb answers in one access cycle, moves finish within eight
// Notes:   off-chip contents are checked by the bench reading the memory model's array
module tb_external_data_ram_external_memory_access;
  timeunit 1ns;
  timeprecision 1ns;
  logic               pclk;
  logic               presetn;
  logic [11:0]        paddr;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [31:0]        pwdata;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               mv_valid;
  xem_pkg::xem_req_s  mv_req;
  logic               mv_ready;
  logic               mv_done;
  logic [7:0]         mv_rdata;
  logic               fl_wr;
  logic [15:0]        fl_addr;
  logic [7:0]         fl_data;
  xem_pkg::xem_pins_s pin_in;
  xem_pkg::xem_pins_s pin_out;
  xem_pkg::xem_pins_s pin_oe;
  logic               shared;
  logic               slow;
  logic [31:0]        rdat;
  logic               rerr;
  int                 fails;
  int                 compares;
  int                 fl_cnt;

  xem_access u_dut (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .mv_valid, .mv_req, .mv_ready, .mv_done, .mv_rdata,
    .fl_wr, .fl_addr, .fl_data, .pin_in, .pin_out, .pin_oe
  );
  xem_ext_mem u_mem (.pclk, .shared, .slow, .pin_out, .pin_oe, .pin_in);

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk)
    if (fl_wr === 1'b1)
      fl_cnt <= fl_cnt + 1;

  task automatic final_report();
    if (fails == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic tmo(input string nm);
    fails++;
    $display("[ERR] %s exp handshake got timeout", nm);
    final_report();
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16)
      tmo("pready");
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // req is {pointer form, index b, write, data}
  task automatic mv(input logic [10:0] req);
    int n;
    n = 0;
    mv_valid <= 1'b1;
    mv_req   <= req;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (mv_ready !== 1'b1 && n < 16);
    mv_valid <= 1'b0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (mv_done !== 1'b1 && n < 32);
    if (n >= 32)
      tmo("move");
  endtask

  task automatic cfg(input logic sep, input logic [1:0] md);
    shared <= !sep;
    apb(1'b1, xem_pkg::XEM_A_CFG, {27'h0, sep, md, 2'h3});
  endtask

  task automatic t_regs();
    apb(1'b0, xem_pkg::XEM_A_PAGE, 32'h0);
    chk("page reset", rdat, 32'h0);
    apb(1'b0, xem_pkg::XEM_A_LATCH, 32'h0);
    chk("latch reset", rdat, 32'h7ffffff);
    apb(1'b0, 12'hffc, 32'h0);
    chk("unmapped err", rerr, 32'h1);
    apb(1'b1, xem_pkg::XEM_A_PAGE, 32'hffffffff);
    apb(1'b0, xem_pkg::XEM_A_PAGE, 32'h0);
    chk("page rw", rdat, 32'hff);
    apb(1'b1, xem_pkg::XEM_A_PTR_HI, 32'h12);
    apb(1'b1, xem_pkg::XEM_A_PTR_LO, 32'h34);
    apb(1'b0, xem_pkg::XEM_A_PTR_HI, 32'h0);
    chk("ptr high", rdat, 32'h12);
    apb(1'b1, xem_pkg::XEM_A_PMODE, 32'h7ffffff);
    apb(1'b1, xem_pkg::XEM_A_LATCH, 32'h7ffffff);
  endtask

  task automatic t_onchip();
    cfg(1'b1, 2'h0);
    mv({3'b101, 8'h5a});
    apb(1'b1, xem_pkg::XEM_A_IDX_B, 32'h34);
    mv({3'b010, 8'h00});
    chk("alias read", mv_rdata, 32'h5a);
    chk("stays inside", u_mem.mem.exists(16'h1234), 32'h0);
  endtask

  task automatic t_split();
    cfg(1'b1, 2'h2);
    apb(1'b1, xem_pkg::XEM_A_PAGE, 32'h12);
    apb(1'b1, xem_pkg::XEM_A_IDX_A, 32'h34);
    mv({3'b001, 8'ha5});
    chk("paged write", u_mem.mem[16'h1234], 32'ha5);
    mv({3'b100, 8'h00});
    chk("ptr read", mv_rdata, 32'ha5);
    apb(1'b1, xem_pkg::XEM_A_PAGE, 32'h13);
    mv({3'b001, 8'h66});
    chk("new page", u_mem.mem[16'h1334], 32'h66);
    apb(1'b1, xem_pkg::XEM_A_PAGE, 32'h00);
    mv({3'b000, 8'h00});
    chk("low page", mv_rdata, 32'h5a);
    cfg(1'b1, 2'h1);
    apb(1'b1, xem_pkg::XEM_A_LATCH, 32'h756ffff);
    u_mem.mem[16'h5634] = 8'h3c;
    apb(1'b1, xem_pkg::XEM_A_PAGE, 32'h12);
    mv({3'b000, 8'h00});
    chk("latch page", mv_rdata, 32'h3c);
    apb(1'b1, xem_pkg::XEM_A_LATCH, 32'h7ffffff);
  endtask

  task automatic t_offmux();
    cfg(1'b0, 2'h3);
    slow <= 1'b1;
    u_mem.mem[16'h1234] = 8'hc3;
    mv({3'b100, 8'h00});
    chk("off only", mv_rdata, 32'hc3);
    mv({3'b101, 8'h99});
    chk("shared write", u_mem.mem[16'h1234], 32'h99);
    slow <= 1'b0;
  endtask

  task automatic t_flash();
    cfg(1'b1, 2'h0);
    apb(1'b1, xem_pkg::XEM_A_CTL, 32'h1);
    mv({3'b101, 8'he7});
    // the pulse counter updates at the edge that ends the move
    @(posedge pclk);
    chk("flash count", fl_cnt, 32'h1);
    chk("flash addr", fl_addr, 32'h1234);
    chk("flash data", fl_data, 32'he7);
    mv({3'b100, 8'h00});
    chk("ram kept", mv_rdata, 32'h5a);
    apb(1'b1, xem_pkg::XEM_A_CTL, 32'h0);
  endtask

  task automatic t_pins();
    cfg(1'b1, 2'h3);
    apb(1'b1, xem_pkg::XEM_A_PMODE, 32'h700ffff);
    apb(1'b1, xem_pkg::XEM_A_LATCH, 32'h70fffff);
    @(posedge pclk);
    chk("open drain idle", pin_oe, 32'h7f0ffff);
    mv({3'b100, 8'h00});
    @(posedge pclk);
    chk("pins back", pin_out, 32'h70fffff);
    chk("oe back", pin_oe, 32'h7f0ffff);
  endtask

  initial
  begin
    fails    = 0;
    compares = 0;
    fl_cnt   = 0;
    presetn  = 1'b0;
    paddr    = 12'h000;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    pwdata   = 32'h0;
    mv_valid = 1'b0;
    mv_req   = '0;
    shared   = 1'b0;
    slow     = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_onchip();
    t_split();
    t_offmux();
    t_flash();
    t_pins();
    final_report();
  end
endmodule
